// file: dv/srm_props.sv
// Checker for the refresh and mode setup block
`timescale 1ns/1ps
`default_nettype none
module srm_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready_q,
  input wire logic pslverr_q,
  // Memory side
  input wire logic [2:0] mem_cmd_q,
  input wire logic [12:0] memory_address_bus_q,
  input wire logic memory_clock_enable_q,
  input wire logic init_done_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready_q;
  a_mode_cas: assert property (mem_cmd_q == 3'h3 |-> memory_address_bus_q[6:4] inside {3'h2, 3'h3})
    else $error("cas bits wrong");
  a_mode_len: assert property (mem_cmd_q == 3'h3 |-> memory_address_bus_q[2:0] inside {3'h2, 3'h3})
    else $error("burst bits wrong");
  a_mode_zero: assert property (mem_cmd_q == 3'h3 |-> !memory_address_bus_q[9:7] && !memory_address_bus_q[3])
    else $error("mode zero bits set");
  a_ext_zero: assert property (mem_cmd_q == 3'h4 |-> memory_address_bus_q[6:3] == 4'h0)
    else $error("ext bits set");
  a_pre_all: assert property (mem_cmd_q == 3'h1 |-> memory_address_bus_q[10])
    else $error("precharge not all");
  a_pre_ref: assert property ((init_done_q && mem_cmd_q == 3'h1) ##1 mem_cmd_q != 3'h1 |-> mem_cmd_q == 3'h2)
    else $error("precharge without refresh");
  a_cmd_holds: assert property ($changed(mem_cmd_q) |=> $stable(mem_cmd_q)[*5])
    else $error("command too short");
  a_cke_run: assert property (init_done_q |-> memory_clock_enable_q)
    else $error("clock enable low");
  a_ready_one: assert property ($rose(psel && penable) |=> pready_q ##1 !pready_q)
    else $error("ready timing");
  a_err_map: assert property (acc && (paddr > 8'h14 || (pwrite && paddr == 8'h14)) |-> pslverr_q)
    else $error("no slave error");
  c_mode: cover property (mem_cmd_q == 3'h3);
  c_ref: cover property (init_done_q && mem_cmd_q == 3'h2);
  c_err: cover property (acc && pslverr_q);
  c_ext: cover property (mem_cmd_q == 3'h4);
endmodule
bind srm_top srm_props srm_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready_q, .pslverr_q,
  .mem_cmd_q, .memory_address_bus_q, .memory_clock_enable_q, .init_done_q);
`default_nettype wire

// file: dv/srm_sdram_model.sv
// SDRAM model: makes the memory clock and logs commands
`timescale 1ns/1ps
`default_nettype none
module srm_sdram_model (
  // Clock out
  output var logic memory_clock,
  // Commands
  input wire logic [2:0] mem_cmd_q,
  input wire logic [12:0] memory_address_bus_q,
  // Log
  output var int ref_cnt,
  output var int mode_cnt,
  output var int init_refs,
  output var logic [12:0] last_mode,
  output var logic [12:0] last_ext
);
  int since_pre;
  initial
  begin
    memory_clock = 1'b0;
    ref_cnt = 0;
    mode_cnt = 0;
    init_refs = 0;
    since_pre = 0;
    last_mode = 13'h0000;
    last_ext = 13'h0000;
    #37;
    forever #100 memory_clock = ~memory_clock;
  end
  // Commands stand a full memory clock, so sample at its rise
  always @(posedge memory_clock)
  begin
    if (mem_cmd_q == 3'h1)
      since_pre = 0;
    if (mem_cmd_q == 3'h2)
    begin
      ref_cnt++;
      since_pre++;
    end
    if (mem_cmd_q == 3'h4)
      last_ext = memory_address_bus_q;
    if (mem_cmd_q == 3'h3)
    begin
      mode_cnt++;
      last_mode = memory_address_bus_q;
      init_refs = since_pre;
    end
  end
endmodule
`default_nettype wire

// file: dv/test_srm_top.sv
// Self-checking bench for the refresh and mode setup block
`timescale 1ns/1ps
`default_nettype none
module test_srm_top;
  logic pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q, memory_clock, er;
  logic req_pending, rd_pending, bank_open, memory_clock_enable_q, refresh_hold_q, init_done_q;
  logic low_power_request_q, selfrefresh_powerdown_select_q, access_busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_q, rd;
  logic [3:0] pstrb;
  logic [2:0] mem_cmd_q;
  logic [12:0] memory_address_bus_q, last_mode, last_ext;
  int error_cnt, checks_done, ref_cnt, mode_cnt, init_refs, n, m0, r0;
  srm_top srm_top_inst (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata_q, .pready_q, .pslverr_q, .memory_clock, .req_pending, .rd_pending, .bank_open,
    .access_busy, .mem_cmd_q, .memory_address_bus_q, .memory_clock_enable_q, .refresh_hold_q,
    .init_done_q, .low_power_request_q, .selfrefresh_powerdown_select_q);
  srm_sdram_model srm_sdram_model_inst (.memory_clock, .mem_cmd_q, .memory_address_bus_q, .ref_cnt,
    .mode_cnt, .init_refs, .last_mode, .last_ext);
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp)
      error_cnt++;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready_q !== 1'b1 && n < 50);
    if (pready_q !== 1'b1)
      error_cnt++;
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_mode;
    n = 0;
    while (mode_cnt == m0 && n < 6000)
    begin
      @(posedge pclk);
      n++;
    end
    if (mode_cnt == m0)
      error_cnt++;
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h00, 32'h0, 4'hF);
    chk(rd, 32'h0000_0004);
    apb(1'b0, 8'h04, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0, 4'hF);
    chk(er, 1'b1);
    apb(1'b1, 8'h14, 32'hFF, 4'hF);
    chk(er, 1'b1);
    $display("t_regs done");
  endtask
  task automatic t_init;
    apb(1'b1, 8'h00, 32'h2000_0004, 4'hF);
    apb(1'b1, 8'h08, 32'h1234_5678, 4'hF);
    apb(1'b1, 8'h0C, 32'h0000_0ABC, 4'hF);
    apb(1'b1, 8'h04, 32'h0000_0004, 4'hF);
    m0 = mode_cnt;
    apb(1'b1, 8'h00, 32'h2000_0007, 4'hF);
    wait_mode;
    chk(last_mode, 13'h0033);
    chk(init_refs, 8);
    repeat (40) @(posedge pclk);
    chk({init_done_q, memory_clock_enable_q}, 2'b11);
    m0 = mode_cnt;
    apb(1'b1, 8'h00, 32'h2000_0004, 4'hF);
    wait_mode;
    chk(last_mode, 13'h0022);
    $display("t_init done");
  endtask
  task automatic t_upper;
    m0 = mode_cnt;
    apb(1'b1, 8'h00, 32'h2000_0000, 4'b1000);
    apb(1'b1, 8'h04, 32'h8000_0004, 4'hF);
    repeat (3) @(posedge pclk);
    chk({low_power_request_q, selfrefresh_powerdown_select_q}, 2'b10);
    apb(1'b1, 8'h04, 32'h0000_0004, 4'hF);
    repeat (1200) @(posedge pclk);
    chk(mode_cnt, m0);
    r0 = ref_cnt;
    repeat (800) @(posedge pclk);
    chk((ref_cnt - r0) inside {[17:27]}, 1'b1);
    $display("t_upper done");
  endtask
  task automatic t_urg;
    req_pending <= 1'b1;
    rd_pending <= 1'b1;
    bank_open <= 1'b1;
    access_busy <= 1'b1;
    r0 = ref_cnt;
    m0 = 0;
    do
    begin
      apb(1'b0, 8'h14, 32'h0, 4'hF);
      m0++;
    end
    while (rd[3:0] < 4'hC && m0 < 400);
    chk(refresh_hold_q, 1'b1);
    repeat (250) @(posedge pclk);
    apb(1'b0, 8'h14, 32'h0, 4'hF);
    chk(rd[3:0], 4'hF);
    chk(ref_cnt - r0, 0);
    access_busy <= 1'b0;
    do
    begin
      apb(1'b0, 8'h14, 32'h0, 4'hF);
      m0++;
    end
    while (rd[3:0] > 4'h7 && m0 < 800);
    chk(rd[3:0] inside {[4:7]}, 1'b1);
    repeat (20) @(posedge pclk);
    chk(refresh_hold_q, 1'b0);
    req_pending <= 1'b0;
    rd_pending <= 1'b0;
    repeat (300) @(posedge pclk);
    apb(1'b0, 8'h14, 32'h0, 4'hF);
    chk(rd[3:0] inside {[3:4]}, 1'b1);
    bank_open <= 1'b0;
    repeat (200) @(posedge pclk);
    apb(1'b0, 8'h14, 32'h0, 4'hF);
    chk(rd[3:0] <= 4'h1, 1'b1);
    $display("t_urg done");
  endtask
  task automatic t_mobile;
    m0 = mode_cnt;
    apb(1'b1, 8'h00, 32'h2200_0004, 4'hF);
    apb(1'b1, 8'h10, 32'h0000_0005, 4'hF);
    wait_mode;
    chk(last_ext, 13'h0005);
    chk(last_mode, 13'h0022);
    $display("t_mobile done");
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {req_pending, rd_pending, bank_open, access_busy} = '0;
    error_cnt = 0;
    checks_done = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_init;
    t_upper;
    t_urg;
    t_mobile;
    complete_run;
  end
  initial
  begin
    #(25 * 30000);
    error_cnt++;
    complete_run;
  end
endmodule
`default_nettype wire

// file: verilog/srm_consts.vh
// Constants for the SDRAM refresh and mode setup block
`ifndef SRM_CONSTS_VH
`define SRM_CONSTS_VH
// Register byte offsets
`define SRM_OFF_CONFIG 8'h00
`define SRM_OFF_REFRESH 8'h04
`define SRM_OFF_TIMING_ONE 8'h08
`define SRM_OFF_TIMING_TWO 8'h0C
`define SRM_OFF_CONFIG_TWO 8'h10
`define SRM_OFF_STATUS 8'h14
// Config register fields
`define SRM_CFG_NM_BIT 0
`define SRM_CFG_CL_LSB 1
`define SRM_CFG_CL_MSB 3
`define SRM_CFG_MOBILE_BIT 25
`define SRM_CFG_ENABLE_BIT 29
// Refresh control fields
`define SRM_RFC_RATE_MSB 12
`define SRM_RFC_SRPD_BIT 30
`define SRM_RFC_LP_BIT 31
// Config two field
`define SRM_CFG2_PARTIAL_ARRAY_REFRESH_FIELD_MSB 2
// Reset values
`define SRM_RST_CONFIG 32'h0000_0004
`define SRM_RST_REFRESH 32'h0000_0000
`define SRM_RST_TIMING 32'h0000_0000
`define SRM_RST_CONFIG_TWO 32'h0000_0000
// Counter widths and saturation bounds
`define SRM_INTERVAL_W 13
`define SRM_BACKLOG_MAX 4'hF
`define SRM_BACKLOG_MIN 4'h0
// Initialization counts
`define SRM_INIT_INTERVALS 4'h8
`define SRM_INIT_REFRESHES 4'h8
// Memory commands
`define SRM_CMD_NOP 3'h0
`define SRM_CMD_PRE_ALL 3'h1
`define SRM_CMD_REFRESH 3'h2
`define SRM_CMD_LOAD_MODE 3'h3
`define SRM_CMD_LOAD_EXT 3'h4
// Address bit that selects all banks on precharge
`define SRM_A10_ALL 13'h0400
`endif

// file: verilog/srm_mode_word.v
// Load-mode and extended-mode address word builder
`timescale 1ns/1ps
`default_nettype none
module srm_mode_word (
  // Settings
  input wire [2:0] cas_latency_field,
  input wire narrow_width_select,
  input wire [2:0] partial_array_refresh_field,
  // Words
  output wire [12:0] mode_word,
  output wire [12:0] ext_word
);
  wire [2:0] cl_code;
  wire [2:0] bl_code;
  assign cl_code = (cas_latency_field == 3'h2) ? 3'h2 : 3'h3;
  assign bl_code = narrow_width_select ? 3'h3 : 3'h2;
  assign mode_word = {3'h0, 3'h0, cl_code, 1'b0, bl_code};
  assign ext_word = {6'h00, 4'h0, partial_array_refresh_field};
endmodule
`default_nettype wire

// file: verilog/srm_refresh_counters.v
// Refresh interval down-counter and saturating backlog counter
`timescale 1ns/1ps
`default_nettype none
`include "srm_consts.vh"
module srm_refresh_counters #(
  parameter IW = 13
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // Control
  input wire tick,
  input wire load,
  input wire [IW-1:0] rate,
  input wire ref_done,
  // State
  output reg [IW-1:0] interval_q,
  output reg [3:0] backlog_q,
  output reg expire_q
);
  reg armed_q;
  wire expire;
  wire inc;
  wire dec;
  assign expire = tick & armed_q & (interval_q == {IW{1'b0}});
  assign inc = expire & (backlog_q != `SRM_BACKLOG_MAX);
  assign dec = ref_done & (backlog_q != `SRM_BACKLOG_MIN);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interval_q <= {IW{1'b0}};
      backlog_q <= 4'h0;
      armed_q <= 1'b0;
      expire_q <= 1'b0;
    end
    else if (ce)
    begin
      // Expiry flag stands a full memory clock for the tick-driven sequencer
      if (tick)
        expire_q <= expire;
      if (load)
      begin
        interval_q <= rate;
        armed_q <= 1'b1;
      end
      else if (expire)
        interval_q <= rate;
      else if (tick & armed_q)
        interval_q <= interval_q - {{(IW-1){1'b0}}, 1'b1};
      if (inc & ~dec)
        backlog_q <= backlog_q + 4'h1;
      else if (dec & ~inc)
        backlog_q <= backlog_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: verilog/srm_top.v
// SDRAM refresh scheduler, init sequencer and mode setup with APB registers
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "srm_consts.vh"
// How it works
// - Mode load drives address 6..4 with 2 for CAS latency 2, 3 for 3.
// - Mode load drives address 2..0 with 2 for wide, 3 for narrow bus.
// - Extended load for mobile memory carries the partial refresh field in bits 2..0.
// - Init issues precharge all, then eight refreshes, before the mode loads.
// - Every auto refresh from the run state is precharge all followed by refresh; the mode load is followed by a refresh alone.
// - Auto refresh keeps running and cannot be switched off.
// - A 13-bit interval down-counter and a 4-bit backlog counter schedule refresh.
// - With enable set, writing the rate loads the counter; it counts memory clocks.
// - At zero the counter reloads and the backlog rises unless full.
// - Each finished refresh except the eight init refreshes lowers the backlog; it saturates at 0 and 15.
// - Backlog 1-3 refreshes only with no requests and no open bank.
// - Backlog 4-7 refreshes whenever no requests are pending.
// - Backlog 8-11 refreshes after the current access unless reads wait.
// - Backlog 12-15 refreshes repeatedly, holding requests until it reaches 4-7.
// - Writing the config register low bytes restarts initialization.
// - Writing only the config upper byte does not restart initialization.
module srm_top #(
  parameter IW = `SRM_INTERVAL_W
) (
  // Clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // Memory clock from outside
  input wire memory_clock,
  // Access engine status
  input wire req_pending,
  input wire rd_pending,
  input wire bank_open,
  input wire access_busy,
  // Memory command
  output reg [2:0] mem_cmd_q,
  output reg [12:0] memory_address_bus_q,
  output reg memory_clock_enable_q,
  // Status to access engine
  output reg refresh_hold_q,
  output reg init_done_q,
  output reg low_power_request_q,
  output reg selfrefresh_powerdown_select_q
);
  localparam ST_OFF = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_IPRE = 3'h2;
  localparam ST_IREF = 3'h3;
  localparam ST_EMR = 3'h4;
  localparam ST_LMR = 3'h5;
  localparam ST_RUN = 3'h6;
  localparam ST_AREF = 3'h7;

  // Byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // Refresh urgency check by backlog range
  function ref_wanted;
    input [3:0] bl;
    input rq;
    input rd;
    input bo;
    input busy;
    begin
      case (bl[3:2])
        2'h0: ref_wanted = (bl != 4'h0) & ~rq & ~bo;
        2'h1: ref_wanted = ~rq;
        2'h2: ref_wanted = ~busy & ~rd;
        2'h3: ref_wanted = ~busy;
        default: ref_wanted = 1'b0;
      endcase
    end
  endfunction

  reg [31:0] config_q;
  reg [31:0] refresh_q;
  reg [31:0] timing_one_q;
  reg [31:0] timing_two_q;
  reg [31:0] config_two_q;
  reg mclk_s1_q;
  reg mclk_s2_q;
  reg mclk_s3_q;
  reg init_req_q;
  reg rate_load_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [3:0] step_q;
  reg [3:0] step_d;
  reg [2:0] cmd_d;
  reg [12:0] addr_d;
  reg [31:0] rdata_d;
  reg hit;
  reg must_q;
  wire acc;
  wire wr;
  wire tick;
  wire init_start;
  wire ref_done;
  wire [12:0] mode_word;
  wire [12:0] ext_word;
  wire [IW-1:0] interval;
  wire [3:0] backlog;
  wire expire;
  wire enable;
  wire mobile;
  wire must;

  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite;
  assign tick = mclk_s2_q & ~mclk_s3_q;
  assign enable = config_q[`SRM_CFG_ENABLE_BIT];
  assign mobile = config_q[`SRM_CFG_MOBILE_BIT];
  assign init_start = wr & (((paddr == `SRM_OFF_CONFIG) & (|pstrb[1:0]))
    | ((paddr == `SRM_OFF_CONFIG_TWO) & mobile));
  assign ref_done = tick & (state_q == ST_AREF);
  // Must level holds from backlog 12 until it falls below 8
  assign must = (backlog[3:2] == 2'h3) | (must_q & backlog[3]);

  srm_mode_word u_mode (
    .cas_latency_field(config_q[`SRM_CFG_CL_MSB:`SRM_CFG_CL_LSB]),
    .narrow_width_select(config_q[`SRM_CFG_NM_BIT]),
    .partial_array_refresh_field(config_two_q[`SRM_CFG2_PARTIAL_ARRAY_REFRESH_FIELD_MSB:0]),
    .mode_word(mode_word),
    .ext_word(ext_word)
  );

  srm_refresh_counters #(
    .IW(IW)
  ) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(tick),
    .load(rate_load_q),
    .rate(refresh_q[IW-1:0]),
    .ref_done(ref_done),
    .interval_q(interval),
    .backlog_q(backlog),
    .expire_q(expire)
  );

  // Read mux and address decode
  always @*
  begin
    hit = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr)
      `SRM_OFF_CONFIG: rdata_d = config_q;
      `SRM_OFF_REFRESH: rdata_d = refresh_q;
      `SRM_OFF_TIMING_ONE: rdata_d = timing_one_q;
      `SRM_OFF_TIMING_TWO: rdata_d = timing_two_q;
      `SRM_OFF_CONFIG_TWO: rdata_d = config_two_q;
      `SRM_OFF_STATUS: rdata_d = {{(24-IW){1'b0}}, interval, init_done_q, state_q, backlog};
      default: hit = 1'b0;
    endcase
  end

  // APB slave, one wait cycle per access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      config_q <= `SRM_RST_CONFIG;
      refresh_q <= `SRM_RST_REFRESH;
      timing_one_q <= `SRM_RST_TIMING;
      timing_two_q <= `SRM_RST_TIMING;
      config_two_q <= `SRM_RST_CONFIG_TWO;
      rate_load_q <= 1'b0;
    end
    else if (ce)
    begin
      pready_q <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q)
      begin
        pslverr_q <= ~hit | (pwrite & (paddr == `SRM_OFF_STATUS));
        prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      end
      else
      begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
      end
      rate_load_q <= wr & (paddr == `SRM_OFF_REFRESH) & (|pstrb[1:0]) & enable;
      if (wr)
      begin
        case (paddr)
          `SRM_OFF_CONFIG: config_q <= merge(config_q, pwdata, pstrb);
          `SRM_OFF_REFRESH: refresh_q <= merge(refresh_q, pwdata, pstrb);
          `SRM_OFF_TIMING_ONE: timing_one_q <= merge(timing_one_q, pwdata, pstrb);
          `SRM_OFF_TIMING_TWO: timing_two_q <= merge(timing_two_q, pwdata, pstrb);
          `SRM_OFF_CONFIG_TWO: config_two_q <= merge(config_two_q, pwdata, pstrb);
          default: config_q <= config_q;
        endcase
      end
    end
  end

  // Memory clock synchronizer and pending init request
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mclk_s1_q <= 1'b0;
      mclk_s2_q <= 1'b0;
      mclk_s3_q <= 1'b0;
      init_req_q <= 1'b0;
    end
    else if (ce)
    begin
      mclk_s1_q <= memory_clock;
      mclk_s2_q <= mclk_s1_q;
      mclk_s3_q <= mclk_s2_q;
      // New request wins over consumption
      if (init_start)
        init_req_q <= 1'b1;
      // Kept through a refresh in progress
      else if (tick & (state_q != ST_AREF))
        init_req_q <= 1'b0;
    end
  end

  // Init sequence and refresh scheduler, one command per memory clock
  always @*
  begin
    state_d = state_q;
    step_d = step_q;
    cmd_d = `SRM_CMD_NOP;
    addr_d = 13'h0000;
    if (init_req_q & enable & (state_q != ST_AREF))
    begin
      state_d = ST_WAIT;
      step_d = 4'h0;
      if (bank_open)
      begin
        cmd_d = `SRM_CMD_PRE_ALL;
        addr_d = `SRM_A10_ALL;
      end
    end
    else
    begin
      case (state_q)
        ST_OFF: state_d = ST_OFF;
        ST_WAIT:
        begin
          if (expire)
            step_d = step_q + 4'h1;
          if (step_q == `SRM_INIT_INTERVALS)
          begin
            state_d = ST_IPRE;
            step_d = 4'h0;
          end
        end
        ST_IPRE:
        begin
          cmd_d = `SRM_CMD_PRE_ALL;
          addr_d = `SRM_A10_ALL;
          state_d = ST_IREF;
        end
        ST_IREF:
        begin
          cmd_d = `SRM_CMD_REFRESH;
          step_d = step_q + 4'h1;
          if (step_q == `SRM_INIT_REFRESHES - 4'h1)
            state_d = mobile ? ST_EMR : ST_LMR;
        end
        ST_EMR:
        begin
          cmd_d = `SRM_CMD_LOAD_EXT;
          addr_d = ext_word;
          state_d = ST_LMR;
        end
        ST_LMR:
        begin
          cmd_d = `SRM_CMD_LOAD_MODE;
          addr_d = mode_word;
          state_d = ST_AREF;
        end
        ST_RUN:
        begin
          if (ref_wanted(backlog, req_pending, rd_pending, bank_open, access_busy)
            | (must & ~access_busy))
          begin
            cmd_d = `SRM_CMD_PRE_ALL;
            addr_d = `SRM_A10_ALL;
            state_d = ST_AREF;
          end
        end
        ST_AREF:
        begin
          cmd_d = `SRM_CMD_REFRESH;
          state_d = ST_RUN;
        end
        default: state_d = ST_OFF;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_OFF;
      step_q <= 4'h0;
      mem_cmd_q <= `SRM_CMD_NOP;
      memory_address_bus_q <= 13'h0000;
      memory_clock_enable_q <= 1'b0;
      refresh_hold_q <= 1'b0;
      init_done_q <= 1'b0;
      low_power_request_q <= 1'b0;
      selfrefresh_powerdown_select_q <= 1'b0;
      must_q <= 1'b0;
    end
    else if (ce)
    begin
      low_power_request_q <= refresh_q[`SRM_RFC_LP_BIT];
      selfrefresh_powerdown_select_q <= refresh_q[`SRM_RFC_SRPD_BIT];
      // Requests held during init, refresh, and from backlog 12 until it falls to 7
      refresh_hold_q <= (state_q != ST_RUN) | must;
      must_q <= must;
      init_done_q <= (state_q == ST_RUN) | (state_q == ST_AREF & init_done_q);
      if (tick)
      begin
        state_q <= state_d;
        step_q <= step_d;
        mem_cmd_q <= cmd_d;
        memory_address_bus_q <= addr_d;
        memory_clock_enable_q <= (state_d != ST_OFF);
      end
    end
  end
endmodule
`default_nettype wire
